// ===== hdl/psc_cmd_decoder.sv
`timescale 1ns/1ps
`include "psc_defines.svh"


module psc_cmd_decoder (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  output logic rx_ready,
  output logic tx_valid,
  input wire logic tx_ready,
  output logic [7:0] tx_data,
  output logic nv_req,
  output logic nv_we,
  output logic [5:0] nv_addr,
  output psc_pkg::psc_word_t nv_wdata,
  input wire logic nv_ack,
  input psc_pkg::psc_word_t nv_rdata,
  input wire logic user_autoload,
  output logic [7:0] module_addr,
  output logic load_done,
  input wire logic axis_set_en,
  input wire logic [4:0] axis_set_idx,
  input psc_pkg::psc_word_t axis_set_data,
  input wire logic [4:0] axis_get_idx,
  output psc_pkg::psc_word_t axis_get_data
);
  import psc_pkg::*;

  // --------------------------------------------------------------------
  // Frame receiver
  // --------------------------------------------------------------------
  psc_frame_if fr ();

  psc_frame_rx u_rx (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .rx_valid(rx_valid),
    .rx_data(rx_data),
    .rx_ready(rx_ready),
    .fr(fr.rx)
  );

  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------
  psc_state_e state_reg, state_next;
  logic [5:0] cnt_reg, cnt_next, uoff;
  logic [7:0] op_reg, op_next, kind_reg, kind_next, sel_reg, sel_next;
  logic [7:0] status_reg, status_next, addr_reg, addr_next;
  logic [7:0] tx_data_reg, tx_data_next;
  logic [3:0] tx_idx_reg, tx_idx_next;
  psc_word_t rval_reg, rval_next, nv_wdata_reg, nv_wdata_next;
  logic nv_req_reg, nv_req_next, nv_we_reg, nv_we_next;
  logic [5:0] nv_addr_reg, nv_addr_next;
  psc_word_t axis_reg [`PSC_AXIS_WORDS];
  psc_word_t axis_next [`PSC_AXIS_WORDS];
  psc_word_t user_reg [`PSC_USER_WORDS];
  psc_word_t user_next [`PSC_USER_WORDS];
  psc_word_t irq_reg [`PSC_IRQ_WORDS];
  psc_word_t irq_next [`PSC_IRQ_WORDS];
  psc_word_t get_reg, get_next;
  logic auto_meta_reg, auto_sync_reg;
  logic take;
  psc_frame_s f;
  logic [4:0] cmd_ax_idx, cur_ax_idx;
  logic [5:0] cmd_user_nv;
  logic hit_ok;
  logic [7:0] rep_byte [`PSC_HDR_BYTES];
  logic [7:0] rep_sum;

  // Axis words are packed as motor times eight plus parameter number.
  function automatic logic [4:0] axis_idx(input logic [7:0] sel,
                                          input logic [7:0] kind);
    return {sel[1:0], kind[2:0]};
  endfunction

  function automatic logic axis_ok(input logic [7:0] sel,
                                   input logic [7:0] kind);
    return (sel < `PSC_AXES) && (kind < `PSC_AXIS_TYPES);
  endfunction

  // Decode helpers and fixed outputs.
  assign f = fr.frame;
  assign fr.take = take;
  assign cmd_ax_idx = axis_idx(f.sel, f.kind);
  assign cur_ax_idx = axis_idx(sel_reg, kind_reg);
  assign cmd_user_nv = `PSC_NV_USER_BASE + {2'b00, f.kind[3:0]};
  assign uoff = cnt_reg - `PSC_NV_USER_BASE;
  assign hit_ok = (state_reg == PSC_IDLE) && fr.valid &&
                  (f.addr == addr_reg) && fr.sum_ok;
  assign tx_valid = (state_reg == PSC_REPLY);
  assign tx_data = tx_data_reg;
  assign nv_req = nv_req_reg;
  assign nv_we = nv_we_reg;
  assign nv_addr = nv_addr_reg;
  assign nv_wdata = nv_wdata_reg;
  assign module_addr = addr_reg;
  assign load_done = (state_reg != PSC_LOAD);
  assign axis_get_data = get_reg;

  // Reply frame bytes; the value goes out most significant byte first.
  assign rep_byte[0] = `PSC_HOST_ADDR;
  assign rep_byte[1] = addr_reg;
  assign rep_byte[2] = status_reg;
  assign rep_byte[3] = op_reg;
  assign rep_byte[4] = rval_reg[31:24];
  assign rep_byte[5] = rval_reg[23:16];
  assign rep_byte[6] = rval_reg[15:8];
  assign rep_byte[7] = rval_reg[7:0];
  assign rep_sum = rep_byte[0] + rep_byte[1] + rep_byte[2] + rep_byte[3] +
                   rep_byte[4] + rep_byte[5] + rep_byte[6] + rep_byte[7];

  // --------------------------------------------------------------------
  // Command sequencing
  // --------------------------------------------------------------------
  // The strap is a pin level, so it passes two flops before use.
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      auto_meta_reg <= 1'b0;
      auto_sync_reg <= 1'b0;
    end
    else
    begin
      auto_meta_reg <= user_autoload;
      auto_sync_reg <= auto_meta_reg;
    end
  end

  // Next-state logic; one request is decoded at a time, so a frame waits
  // in the receiver while a nonvolatile access or a reply is in flight.
  always_comb
  begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    op_next = op_reg;
    kind_next = kind_reg;
    sel_next = sel_reg;
    status_next = status_reg;
    rval_next = rval_reg;
    nv_req_next = nv_req_reg;
    nv_we_next = nv_we_reg;
    nv_addr_next = nv_addr_reg;
    nv_wdata_next = nv_wdata_reg;
    tx_idx_next = tx_idx_reg;
    tx_data_next = tx_data_reg;
    addr_next = addr_reg;
    axis_next = axis_reg;
    user_next = user_reg;
    irq_next = irq_reg;
    take = 1'b0;
    get_next = (axis_get_idx < `PSC_AXIS_IDX_LIM) ?
               axis_reg[axis_get_idx] : 32'h0000_0000;
    if (axis_set_en && axis_set_idx < `PSC_AXIS_IDX_LIM)
      axis_next[axis_set_idx] = axis_set_data;
    case (state_reg)
      PSC_LOAD:
      begin
        nv_req_next = !nv_ack;
        nv_we_next = 1'b0;
        if (nv_ack)
        begin
          if (cnt_reg < `PSC_NV_USER_BASE)
            axis_next[cnt_reg[4:0]] = nv_rdata;
          else if (cnt_reg < `PSC_NV_ADDR_SLOT)
            user_next[uoff[3:0]] = nv_rdata;
          else
            addr_next = nv_rdata[7:0];
          if (cnt_reg == `PSC_NV_ADDR_SLOT)
            state_next = PSC_IDLE;
          else if (cnt_reg == `PSC_NV_USER_BASE - 6'h01 && !auto_sync_reg)
            cnt_next = `PSC_NV_ADDR_SLOT;
          else
            cnt_next = cnt_reg + 6'h01;
          nv_addr_next = cnt_next;
        end
      end
      PSC_IDLE:
      begin
        if (fr.valid)
        begin
          take = 1'b1;
          op_next = f.op;
          kind_next = f.kind;
          sel_next = f.sel;
          rval_next = 32'h0000_0000;
          status_next = `PSC_ST_OK;
          state_next = PSC_REPLY;
          tx_idx_next = 4'h0;
          tx_data_next = rep_byte[0];
          if (f.addr != addr_reg)
            state_next = PSC_IDLE;
          else if (!fr.sum_ok)
            status_next = `PSC_ST_BAD_SUM;
          else
          begin
            case (f.op)
              `PSC_OP_STORE_AXIS, `PSC_OP_RESTORE_AXIS:
              begin
                if (axis_ok(f.sel, f.kind))
                begin
                  nv_req_next = 1'b1;
                  nv_we_next = (f.op == `PSC_OP_STORE_AXIS);
                  nv_addr_next = {1'b0, cmd_ax_idx};
                  nv_wdata_next = axis_reg[cmd_ax_idx];
                  state_next = PSC_NV;
                end
                else
                  status_next = `PSC_ST_BAD_TYPE;
              end
              `PSC_OP_SET_GLOBAL:
              begin
                if (f.sel == `PSC_BANK_MODULE && f.kind == `PSC_TYPE_ADDR)
                begin
                  if (f.value[31:8] != 24'h00_0000)
                    status_next = `PSC_ST_BAD_VALUE;
                  else
                  begin
                    addr_next = f.value[7:0];
                    nv_req_next = 1'b1;
                    nv_we_next = 1'b1;
                    nv_addr_next = `PSC_NV_ADDR_SLOT;
                    nv_wdata_next = f.value;
                    state_next = PSC_NV;
                  end
                end
                else if (f.sel == `PSC_BANK_USER && f.kind < `PSC_USER_VARS)
                  user_next[f.kind[3:0]] = f.value;
                else if (f.sel == `PSC_BANK_IRQ && f.kind < `PSC_IRQ_CFGS)
                  irq_next[f.kind[2:0]] = f.value;
                else
                  status_next = `PSC_ST_BAD_TYPE;
              end
              `PSC_OP_GET_GLOBAL:
              begin
                if (f.sel == `PSC_BANK_MODULE && f.kind == `PSC_TYPE_ADDR)
                  rval_next = {24'h00_0000, addr_reg};
                else if (f.sel == `PSC_BANK_USER && f.kind < `PSC_USER_VARS)
                  rval_next = user_reg[f.kind[3:0]];
                else if (f.sel == `PSC_BANK_IRQ && f.kind < `PSC_IRQ_CFGS)
                  rval_next = irq_reg[f.kind[2:0]];
                else
                  status_next = `PSC_ST_BAD_TYPE;
              end
              `PSC_OP_STORE_GLOBAL, `PSC_OP_RESTORE_GLOBAL:
              begin
                if (f.sel == `PSC_BANK_USER && f.kind < `PSC_USER_VARS)
                begin
                  nv_req_next = 1'b1;
                  nv_we_next = (f.op == `PSC_OP_STORE_GLOBAL);
                  nv_addr_next = cmd_user_nv;
                  nv_wdata_next = user_reg[f.kind[3:0]];
                  state_next = PSC_NV;
                end
                else
                  status_next = `PSC_ST_BAD_TYPE;
              end
              default:
                status_next = `PSC_ST_BAD_CMD;
            endcase
          end
        end
      end
      PSC_NV:
      begin
        if (nv_ack)
        begin
          nv_req_next = 1'b0;
          state_next = PSC_REPLY;
          if (!nv_we_reg && op_reg == `PSC_OP_RESTORE_AXIS)
            axis_next[cur_ax_idx] = nv_rdata;
          else if (!nv_we_reg)
            user_next[kind_reg[3:0]] = nv_rdata;
        end
      end
      default:
      begin
        if (tx_ready)
        begin
          tx_idx_next = tx_idx_reg + 4'h1;
          if (tx_idx_reg == `PSC_FRAME_LAST)
            state_next = PSC_IDLE;
          else if (tx_idx_next == `PSC_FRAME_LAST)
            tx_data_next = rep_sum;
          else
            tx_data_next = rep_byte[tx_idx_next[2:0]];
        end
      end
    endcase
  end

  // Registers; parameters start cleared; the power-up load fills axis words and, with the strap high, user words, never irq words.
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      state_reg <= PSC_LOAD;
      cnt_reg <= 6'h00;
      op_reg <= 8'h00;
      kind_reg <= 8'h00;
      sel_reg <= 8'h00;
      status_reg <= 8'h00;
      rval_reg <= 32'h0000_0000;
      nv_req_reg <= 1'b0;
      nv_we_reg <= 1'b0;
      nv_addr_reg <= 6'h00;
      nv_wdata_reg <= 32'h0000_0000;
      tx_idx_reg <= 4'h0;
      tx_data_reg <= 8'h00;
      addr_reg <= `PSC_ADDR_RESET;
      axis_reg <= '{default: 32'h0000_0000};
      user_reg <= '{default: 32'h0000_0000};
      irq_reg <= '{default: 32'h0000_0000};
      get_reg <= 32'h0000_0000;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      op_reg <= op_next;
      kind_reg <= kind_next;
      sel_reg <= sel_next;
      status_reg <= status_next;
      rval_reg <= rval_next;
      nv_req_reg <= nv_req_next;
      nv_we_reg <= nv_we_next;
      nv_addr_reg <= nv_addr_next;
      nv_wdata_reg <= nv_wdata_next;
      tx_idx_reg <= tx_idx_next;
      tx_data_reg <= tx_data_next;
      addr_reg <= addr_next;
      axis_reg <= axis_next;
      user_reg <= user_next;
      irq_reg <= irq_next;
      get_reg <= get_next;
    end
  end

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  property p_store_axis;
    (hit_ok && f.op == `PSC_OP_STORE_AXIS && axis_ok(f.sel, f.kind)) |=>
      nv_req && nv_we && nv_addr == {1'b0, $past(cmd_ax_idx)};
  endproperty
  a_store_axis: assert property (p_store_axis)
    else $error("Axis store did not start a write.");

  property p_restore_axis;
    (state_reg == PSC_NV && nv_ack && !nv_we &&
     op_reg == `PSC_OP_RESTORE_AXIS) |=>
      axis_reg[$past(cur_ax_idx)] == $past(nv_rdata);
  endproperty
  a_restore_axis: assert property (p_restore_axis)
    else $error("Axis restore did not load the word.");

  property p_load_first;
    $rose(load_done) |-> $past(nv_ack) &&
      $past(nv_addr) == `PSC_NV_ADDR_SLOT;
  endproperty
  a_load_first: assert property (p_load_first)
    else $error("Commands enabled before the load ended.");

  property p_set_user;
    (hit_ok && f.op == `PSC_OP_SET_GLOBAL && f.sel == `PSC_BANK_USER &&
     f.kind < `PSC_USER_VARS) |=>
      user_reg[$past(f.kind[3:0])] == $past(f.value) && tx_valid;
  endproperty
  a_set_user: assert property (p_set_user)
    else $error("User variable write lost.");

  property p_bank0_commit;
    (hit_ok && f.op == `PSC_OP_SET_GLOBAL && f.sel == `PSC_BANK_MODULE &&
     f.kind == `PSC_TYPE_ADDR && f.value[31:8] == 24'h00_0000) |=>
      nv_req && nv_we && nv_addr == `PSC_NV_ADDR_SLOT ##1 !tx_valid;
  endproperty
  a_bank0_commit: assert property (p_bank0_commit)
    else $error("Module setting not committed.");

  property p_addr_change;
    (hit_ok && f.op == `PSC_OP_SET_GLOBAL && f.sel == `PSC_BANK_MODULE &&
     f.kind == `PSC_TYPE_ADDR && f.value[31:8] == 24'h00_0000) |=>
      module_addr == $past(f.value[7:0]);
  endproperty
  a_addr_change: assert property (p_addr_change)
    else $error("Bus address did not follow the write.");

  property p_store_user;
    (hit_ok && f.op == `PSC_OP_STORE_GLOBAL && f.sel == `PSC_BANK_USER &&
     f.kind < `PSC_USER_VARS) |=>
      nv_we && nv_addr == $past(cmd_user_nv);
  endproperty
  a_store_user: assert property (p_store_user)
    else $error("User store went to the wrong slot.");

  property p_nv_reply;
    (state_reg == PSC_NV && nv_ack) |=>
      tx_valid && status_reg == `PSC_ST_OK && tx_data == `PSC_HOST_ADDR;
  endproperty
  a_nv_reply: assert property (p_nv_reply)
    else $error("Nonvolatile access not answered with success.");

  property p_get_reply;
    (hit_ok && f.op == `PSC_OP_GET_GLOBAL && f.sel == `PSC_BANK_USER &&
     f.kind < `PSC_USER_VARS) |=>
      status_reg == `PSC_ST_OK && rval_reg == $past(user_reg[f.kind[3:0]]);
  endproperty
  a_get_reply: assert property (p_get_reply)
    else $error("Read reply lacks status or value.");

  property p_bad_sum;
    (state_reg == PSC_IDLE && fr.valid && f.addr == addr_reg &&
     !fr.sum_ok) |=> tx_valid && status_reg == `PSC_ST_BAD_SUM;
  endproperty
  a_bad_sum: assert property (p_bad_sum)
    else $error("Checksum error not reported.");

  c_restore_user: cover property (hit_ok &&
                                  f.op == `PSC_OP_RESTORE_GLOBAL);
  c_load_end: cover property ($rose(load_done));
  c_nv_read: cover property (state_reg == PSC_NV && nv_ack && !nv_we);

endmodule

// ===== hdl/psc_defines.svh
`ifndef PSC_DEFINES_SVH
`define PSC_DEFINES_SVH

// ----------------------------------------------------------------------
// Instruction codes
// ----------------------------------------------------------------------
`define PSC_OP_STORE_AXIS 8'h07
`define PSC_OP_RESTORE_AXIS 8'h08
`define PSC_OP_SET_GLOBAL 8'h09
`define PSC_OP_GET_GLOBAL 8'h0A
`define PSC_OP_STORE_GLOBAL 8'h0B
`define PSC_OP_RESTORE_GLOBAL 8'h0C

// ----------------------------------------------------------------------
// Banks, parameter numbers and reply status codes
// ----------------------------------------------------------------------
`define PSC_BANK_MODULE 8'h00
`define PSC_BANK_USER 8'h02
`define PSC_BANK_IRQ 8'h03
`define PSC_TYPE_ADDR 8'h42
`define PSC_ST_OK 8'h64
`define PSC_ST_BAD_SUM 8'h01
`define PSC_ST_BAD_CMD 8'h02
`define PSC_ST_BAD_TYPE 8'h03
`define PSC_ST_BAD_VALUE 8'h04

// ----------------------------------------------------------------------
// Storage sizes and nonvolatile layout
// ----------------------------------------------------------------------
`define PSC_AXES 8'h03
`define PSC_AXIS_TYPES 8'h08
`define PSC_USER_VARS 8'h10
`define PSC_IRQ_CFGS 8'h08
`define PSC_AXIS_WORDS 24
`define PSC_USER_WORDS 16
`define PSC_IRQ_WORDS 8
`define PSC_AXIS_IDX_LIM 5'h18
`define PSC_NV_USER_BASE 6'h18
`define PSC_NV_ADDR_SLOT 6'h28
`define PSC_ADDR_RESET 8'h01
`define PSC_HOST_ADDR 8'h02
`define PSC_FRAME_LAST 4'h8
`define PSC_HDR_BYTES 8

`endif

// ===== hdl/psc_pkg.sv
package psc_pkg;

  // Decoder sequencing states.
  typedef enum logic [1:0] {PSC_LOAD, PSC_IDLE, PSC_NV, PSC_REPLY} psc_state_e;

  typedef logic [31:0] psc_word_t;

  // Frame header and value, in arrival order.
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] op;
    logic [7:0] kind;
    logic [7:0] sel;
    psc_word_t value;
  } psc_frame_s;

endpackage

// ===== hdl/psc_frame_if.sv
`timescale 1ns/1ps

// Carries one assembled frame from the receiver to the decoder.
interface psc_frame_if;
  logic valid;
  logic sum_ok;
  logic take;
  psc_pkg::psc_frame_s frame;
  modport rx (output valid, output sum_ok, output frame, input take);
  modport dec (input valid, input sum_ok, input frame, output take);
endinterface

// ===== hdl/psc_frame_rx.sv
`timescale 1ns/1ps
`include "psc_defines.svh"

module psc_frame_rx (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  output logic rx_ready,
  psc_frame_if.rx fr
);
  import psc_pkg::*;

  logic [7:0] byte_reg [`PSC_HDR_BYTES];
  logic [7:0] byte_next [`PSC_HDR_BYTES];
  logic [3:0] cnt_reg, cnt_next;
  logic [7:0] sum_reg, sum_next;
  logic pend_reg, pend_next;
  logic ok_reg, ok_next;

  // A held frame blocks the byte stream until the decoder takes it.
  assign rx_ready = !pend_reg;
  assign fr.valid = pend_reg;
  assign fr.sum_ok = ok_reg;
  assign fr.frame = {byte_reg[0], byte_reg[1], byte_reg[2], byte_reg[3],
                     byte_reg[4], byte_reg[5], byte_reg[6], byte_reg[7]};

  // Byte assembly and running checksum.
  always_comb
  begin
    byte_next = byte_reg;
    cnt_next = cnt_reg;
    sum_next = sum_reg;
    pend_next = pend_reg;
    ok_next = ok_reg;
    if (pend_reg && fr.take)
    begin
      pend_next = 1'b0;
      cnt_next = 4'h0;
      sum_next = 8'h00;
    end
    else if (rx_valid && !pend_reg)
    begin
      if (cnt_reg == `PSC_FRAME_LAST)
      begin
        pend_next = 1'b1;
        ok_next = (sum_reg == rx_data);
      end
      else
      begin
        byte_next[cnt_reg[2:0]] = rx_data;
        sum_next = sum_reg + rx_data;
        cnt_next = cnt_reg + 4'h1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      byte_reg <= '{default: 8'h00};
      cnt_reg <= 4'h0;
      sum_reg <= 8'h00;
      pend_reg <= 1'b0;
      ok_reg <= 1'b0;
    end
    else
    begin
      byte_reg <= byte_next;
      cnt_reg <= cnt_next;
      sum_reg <= sum_next;
      pend_reg <= pend_next;
      ok_reg <= ok_next;
    end
  end

  property p_frame_done;
    @(posedge clk_sys) disable iff (!resetn)
    (rx_valid && rx_ready && cnt_reg == `PSC_FRAME_LAST) |=>
      fr.valid && (fr.sum_ok == ($past(sum_reg) == $past(rx_data)));
  endproperty
  a_frame_done: assert property (p_frame_done)
    else $error("Frame end or checksum verdict wrong.");

endmodule

// ===== verif/psc_nv_model.sv
`timescale 1ns/1ps

// ---------------------------------------------------------------
// Nonvolatile word store behind the decoder's access port
// ---------------------------------------------------------------
module psc_nv_model (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic slow,
  input wire logic nv_req,
  input wire logic nv_we,
  input wire logic [5:0] nv_addr,
  input psc_pkg::psc_word_t nv_wdata,
  output logic nv_ack,
  output psc_pkg::psc_word_t nv_rdata
);
  import psc_pkg::*;
  psc_word_t mem [0:63];
  int wait_cnt = 0;

  // Recognisable words; the address slot keeps the reset address.
  initial
  begin
    for (int i = 0; i < 64; i++)
      mem[i] = {24'h5a_0000, 8'(i)};
    mem[40] = 32'h0000_0001;
  end

  // One pulse per access; slow mode makes the decoder wait.
  always @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      nv_ack <= 1'b0;
    else if (nv_req && !nv_ack && wait_cnt >= (slow ? 4 : 0))
    begin
      nv_ack <= 1'b1;
      nv_rdata <= mem[nv_addr];
      if (nv_we)
        mem[nv_addr] <= nv_wdata;
    end
    else
    begin
      nv_ack <= 1'b0;
      nv_rdata <= ~nv_rdata;
    end
  end

  // Cycles spent waiting on the current access.
  always @(posedge clk_sys)
    wait_cnt <= (nv_req && !nv_ack) ? wait_cnt + 1 : 0;
endmodule

// ===== verif/psc_cmd_decoder_tb_top.sv
`timescale 1ns/1ps

module psc_cmd_decoder_tb_top;
  import psc_pkg::*;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic rx_valid = 1'b0;
  logic tx_ready = 1'b0;
  logic slow = 1'b0;
  logic autoload = 1'b1;
  logic axis_set_en = 1'b0;
  logic [7:0] rx_data = 8'h00;
  logic [7:0] cur_addr = 8'h01;
  logic [4:0] axis_set_idx = 5'h00;
  logic [4:0] axis_get_idx = 5'h00;
  psc_word_t axis_set_data = 32'h0000_0000;
  logic rx_ready, tx_valid, nv_req, nv_we, nv_ack, load_done;
  logic [7:0] tx_data, module_addr, st;
  logic [5:0] nv_addr;
  psc_word_t nv_wdata, nv_rdata, axis_get_data, rd;
  int err_total = 0;
  int checks_done = 0;

  always #5 clk_sys = ~clk_sys;

  psc_cmd_decoder dut (.clk_sys(clk_sys), .resetn(resetn),
    .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
    .nv_req(nv_req), .nv_we(nv_we), .nv_addr(nv_addr),
    .nv_wdata(nv_wdata), .nv_ack(nv_ack), .nv_rdata(nv_rdata),
    .user_autoload(autoload), .module_addr(module_addr),
    .load_done(load_done), .axis_set_en(axis_set_en),
    .axis_set_idx(axis_set_idx), .axis_set_data(axis_set_data),
    .axis_get_idx(axis_get_idx), .axis_get_data(axis_get_data));
  psc_nv_model nv (.clk_sys(clk_sys), .resetn(resetn), .slow(slow),
    .nv_req(nv_req), .nv_we(nv_we), .nv_addr(nv_addr),
    .nv_wdata(nv_wdata), .nv_ack(nv_ack), .nv_rdata(nv_rdata));

  // ---------------------------------------------------------------
  // Host side helpers
  // ---------------------------------------------------------------
  // Prints the counts and the verdict, then stops the run.
  task test_done;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Word comparison used for every result.
  task chk(input psc_word_t got, input psc_word_t exp);
    checks_done++;
    if (got !== exp)
    begin
      err_total++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // A wait that ran out counts as a mismatch and ends the run.
  task hang;
    chk(32'h0000_0000, 32'h0000_0001);
    test_done();
  endtask
  // Holds a byte until the edge at which the receiver takes it.
  task put(input logic [7:0] b);
    @(negedge clk_sys);
    rx_valid = 1'b1;
    rx_data = b;
    for (int n = 0; rx_ready !== 1'b1; n++)
    begin
      if (n > 300)
        hang();
      @(negedge clk_sys);
    end
    @(posedge clk_sys);
  endtask
  // frame layout, value MSB first, then the sum plus skew.
  task send(input logic [7:0] op, ty, bk, input psc_word_t v,
            input logic [7:0] skew);
    logic [7:0] b [0:8];
    b = '{cur_addr, op, ty, bk, v[31:24], v[23:16], v[15:8], v[7:0],
          skew};
    for (int i = 0; i < 8; i++)
      b[8] += b[i];
    for (int i = 0; i < 9; i++)
      put(b[i]);
    @(negedge clk_sys);
    rx_valid = 1'b0;
  endtask
  // Takes a whole reply; the sink only accepts once it is listening.
  task recv(input logic [7:0] op, output logic [7:0] s,
            output psc_word_t v);
    logic [7:0] r [0:8];
    logic [7:0] sum;
    for (int n = 0; tx_valid !== 1'b1; n++)
    begin
      if (n > 400)
        hang();
      @(negedge clk_sys);
    end
    tx_ready = 1'b1;
    for (int i = 0; i < 9; i++)
    begin
      r[i] = tx_data;
      @(negedge clk_sys);
    end
    tx_ready = 1'b0;
    sum = 8'h00;
    for (int i = 0; i < 8; i++)
      sum += r[i];
    chk(32'(r[0]), 32'h0000_0002); // Host byte.
    chk(32'(r[1]), 32'(cur_addr)); // Own address.
    chk(32'(r[3]), 32'(op)); // Echo.
    chk(32'(r[8]), 32'(sum)); // Reply sum.
    s = r[2];
    v = {r[4], r[5], r[6], r[7]};
  endtask
  // One command whose reply status is expected.
  task cmd(input logic [7:0] op, ty, bk, input psc_word_t v,
           input logic [7:0] es);
    send(op, ty, bk, v, 8'h00);
    recv(op, st, rd);
    chk(32'(st), 32'(es)); // Status.
  endtask
  // Writes one axis word from the motion side.
  task axis_wr(input logic [4:0] i, input psc_word_t d);
    @(negedge clk_sys);
    axis_set_en = 1'b1;
    axis_set_idx = i;
    axis_set_data = d;
    @(negedge clk_sys);
    axis_set_en = 1'b0;
  endtask
  // Waits, within a bound, until the power-up load has ended.
  task wait_load;
    for (int n = 0; load_done !== 1'b1; n++)
    begin
      if (n > 600)
        hang();
      @(negedge clk_sys);
    end
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  // Power-up load of axis words, user words and address.
  task t_power_up;
    wait_load();
    chk(32'(module_addr), 32'h0000_0001);
    axis_get_idx = 5'h05;
    @(negedge clk_sys);
    chk(axis_get_data, 32'h5a00_0005);
    cmd(8'h0a, 8'h03, 8'h02, 32'hffff_ffff, 8'h64);
    chk(rd, 32'h5a00_001b);
    $display("test power_up done");
  endtask
  // Set and get in banks 2 and 3; bank 1 is refused.
  task t_globals;
    cmd(8'h09, 8'h04, 8'h02, 32'h1234_5678, 8'h64);
    cmd(8'h09, 8'h01, 8'h03, 32'h0000_00a5, 8'h64);
    cmd(8'h0a, 8'h04, 8'h02, 32'h0000_0000, 8'h64);
    chk(rd, 32'h1234_5678);
    cmd(8'h0a, 8'h01, 8'h03, 32'h0000_0000, 8'h64);
    chk(rd, 32'h0000_00a5);
    cmd(8'h09, 8'h04, 8'h01, 32'h0000_0000, 8'h03);
    $display("test globals done");
  endtask
  // Store and restore of a user word with a slow memory.
  task t_user_nv;
    slow = 1'b1;
    cmd(8'h0b, 8'h04, 8'h02, 32'hdead_beef, 8'h64);
    chk(nv.mem[28], 32'h1234_5678);
    cmd(8'h09, 8'h04, 8'h02, 32'h0000_0000, 8'h64);
    cmd(8'h0c, 8'h04, 8'h02, 32'hdead_beef, 8'h64);
    cmd(8'h0a, 8'h04, 8'h02, 32'h0000_0000, 8'h64);
    chk(rd, 32'h1234_5678);
    slow = 1'b0;
    $display("test user_nv done");
  endtask
  // Store and restore of axis word motor 1 type 1.
  task t_axis;
    axis_wr(5'h09, 32'hcafe_0009);
    cmd(8'h07, 8'h01, 8'h01, 32'hffff_ffff, 8'h64);
    chk(nv.mem[9], 32'hcafe_0009);
    axis_wr(5'h09, 32'h0000_0000);
    cmd(8'h08, 8'h01, 8'h01, 32'hffff_ffff, 8'h64);
    axis_get_idx = 5'h09;
    @(negedge clk_sys);
    chk(axis_get_data, 32'hcafe_0009);
    $display("test axis done");
  endtask
  // Address change commits itself; the old address goes quiet.
  task t_address;
    send(8'h09, 8'h42, 8'h00, 32'h0000_0003, 8'h00);
    cur_addr = 8'h03;
    recv(8'h09, st, rd);
    chk(32'(st), 32'h0000_0064);
    chk(32'(module_addr), 32'h0000_0003);
    chk(nv.mem[40], 32'h0000_0003);
    cur_addr = 8'h01;
    send(8'h0a, 8'h42, 8'h00, 32'h0000_0000, 8'h00);
    repeat (20) @(negedge clk_sys);
    chk(32'(tx_valid), 32'h0000_0000);
    cur_addr = 8'h03;
    cmd(8'h0a, 8'h42, 8'h00, 32'h0000_0000, 8'h64);
    chk(rd, 32'h0000_0003);
    send(8'h0a, 8'h04, 8'h02, 32'h0000_0000, 8'h01);
    recv(8'h0a, st, rd);
    chk(32'(st), 32'h0000_0001); // Bad sum.
    $display("test address done");
  endtask
  // Strap low and a second reset: axis words and the stored address come
  // back, user variables stay cleared until the host restores them.
  task t_strap;
    autoload = 1'b0;
    resetn = 1'b0;
    repeat (2) @(negedge clk_sys);
    resetn = 1'b1;
    wait_load();
    chk(32'(module_addr), 32'h0000_0003);
    chk(axis_get_data, 32'hcafe_0009);
    cmd(8'h0a, 8'h03, 8'h02, 32'h0000_0000, 8'h64);
    chk(rd, 32'h0000_0000);
    $display("test strap done");
  endtask

  // Reset for two cycles, then run every scenario.
  initial
  begin
    repeat (2) @(negedge clk_sys);
    resetn = 1'b1;
    t_power_up();
    t_globals();
    t_user_nv();
    t_axis();
    t_address();
    t_strap();
    test_done();
  end
endmodule
